// File: tape_dist_pkg.sv
package tape_dist_pkg;
	// ==========================================================
	// Shaft states
	typedef enum logic [0:0] {
		SH_IDLE = 1'b0,
		SH_RUN = 1'b1
	} shaft_t;

	// ==========================================================
	// Time base
	localparam int CLK_NS = 20;
	localparam int STEP_NS = 2000;
	localparam logic [6:0] STEP_CYCLES = 7'(STEP_NS / CLK_NS);
	localparam logic [8:0] PH_LAST = 9'h167;

	// ==========================================================
	// Contact angles in whole degrees, close inclusive, open exclusive
	localparam logic [8:0] DTRIP2_CL = 9'h05E;
	localparam logic [8:0] DTRIP2_OP = 9'h09C;
	localparam logic [8:0] DTRIP1_CL = 9'h0F7;
	localparam logic [8:0] DTRIP1_OP = 9'h135;
	localparam logic [8:0] AUXA2_CL = 9'h019;
	localparam logic [8:0] AUXA2_OP = 9'h0AA;
	localparam logic [8:0] AUXA1_CL = 9'h032;
	localparam logic [8:0] AUXA1_OP = 9'h154;
	localparam logic [8:0] AUXB_CL = 9'h05F;
	localparam logic [8:0] AUXB_OP = 9'h139;
	localparam logic [8:0] SENSE_LATCH = 9'h01E;
	localparam logic [8:0] START_END = 9'h031;
	localparam logic [8:0] BIT_W = 9'h030;

	// ==========================================================
	// Register map
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] PHASE_OFS = 8'h08;
	localparam logic [7:0] ISTAT_OFS = 8'h0C;
	localparam logic [7:0] IMASK_OFS = 8'h10;
	localparam logic [5:0] CTRL_RST = 6'h00;
	localparam logic [3:0] IMASK_RST = 4'h0;
	localparam int C_RUN = 0;
	localparam int C_ONE = 1;
	localparam int C_BEN = 2;
	localparam int C_WARN = 3;
	localparam int C_STOP = 4;
	localparam int C_SER = 5;
	localparam int I_SENSED = 0;
	localparam int I_SENT = 1;
	localparam int I_TAPEOUT = 2;
	localparam int I_HALT = 3;
endpackage

// File: tape_code_distributor.sv
// Notes on behaviour
// (R1) A distributor revolution starts only from the trip contact worked by the sensing shaft.
// (R2) The trip contact is on from 94 to 156 degrees (2-cycle) or 247 to 309 degrees (1-cycle).
// (R3) The distributor trips, turns and stops exactly like the sensing shaft.
// (R4) A shaft keeps turning while tripped, else ends its revolution and halts at home.
// (R5) The code sensed last is held and kept steady while the distributor sends it.
// (R6) Each code window in series with its stored level drives the line pattern.
// (R7) In 2-cycle gearing distributor output A is on from 25 to 170 degrees.
// (R8) In 1-cycle gearing distributor output A is on from 50 to 340 degrees.
// (R9) Optional 1-cycle output B is on from 94.6 to 312.9 degrees besides A.
// (R10) The tape sensor contact is closed with tape present and open without.
// (R11) The installation picks warning, stop, or both for the tape-out contact.
// (R12) A tape-out stop lets the sensing shaft finish its revolution and halt.
// (R13) An open last-character contact wired in series removes the sensing trip.
// (R14) In continuous sending the next sensing revolution overlaps distribution.
// (R15) Shaft angle is a 360-step counter and each contact is a compare on it.
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
module tape_code_distributor (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	output logic irq,
	// Tape head contacts
	input wire logic [4:0] code_in,
	input wire logic tape_in,
	input wire logic last_char_in,
	// Contacts to the signal circuit
	output logic line_out,
	output logic aux_a,
	output logic aux_b,
	output logic dist_trip,
	output logic tape_warn
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [6:0] s1;
		logic [6:0] s2;
		logic [6:0] s3;
		logic [6:0] filt;
		logic [6:0] step_cnt;
		tape_dist_pkg::shaft_t sns_st;
		logic [8:0] sph;
		tape_dist_pkg::shaft_t dst_st;
		logic [8:0] dph;
		logic [4:0] scode;
		logic [4:0] dcode;
		logic trip;
		logic line;
		logic aux_a;
		logic aux_b;
		logic warn;
		logic irq;
		logic [5:0] ctrl;
		logic [3:0] ist;
		logic [3:0] imask;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} st_t;

	st_t q;
	st_t d;
	logic step;
	logic sns_trip;
	logic [9:0] sns_nx;
	logic [9:0] dst_nx;
	logic [3:0] ev;
	logic acc;
	logic [4:0] lcode;

	// Contact window: closed from cl up to, not including, op
	function automatic logic in_win(input logic [8:0] ph, input logic [8:0] cl,
		input logic [8:0] op);
		in_win = (ph >= cl) && (ph < op);
	endfunction

	// Shaft clutch: trip at home starts one revolution, end of turn resamples trip
	function automatic logic [9:0] shaft_next(input logic run, input logic [8:0] ph,
		input logic stp, input logic trp);
		shaft_next = {run, ph};
		if (run && stp) begin
			if (ph == tape_dist_pkg::PH_LAST) begin
				shaft_next = {trp, 9'h000}; // R4
			end else begin
				shaft_next = {1'b1, 9'(ph + 9'h001)};
			end
		end else if (!run && trp) begin
			shaft_next = {1'b1, ph}; // R3
		end
	endfunction

	// Line level from start window, five code windows and stop window
	function automatic logic line_level(input logic [8:0] ph, input logic [4:0] code);
		logic lv;
		lv = 1'b1;
		if (ph < tape_dist_pkg::START_END) begin
			lv = 1'b0;
		end
		for (int i = 0; i < 5; i++) begin
			if (in_win(ph, 9'(tape_dist_pkg::START_END + 9'(i) * tape_dist_pkg::BIT_W),
				9'(tape_dist_pkg::START_END + 9'(i + 1) * tape_dist_pkg::BIT_W))) begin
				lv = code[i]; // R6
			end
		end
		line_level = lv;
	endfunction

	// Mapped register check, used by the error path only; the read case has its own default
	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == tape_dist_pkg::CTRL_OFS) || (a == tape_dist_pkg::STAT_OFS) ||
			(a == tape_dist_pkg::PHASE_OFS) || (a == tape_dist_pkg::ISTAT_OFS) ||
			(a == tape_dist_pkg::IMASK_OFS);
	endfunction

	// ==========================================================
	// Next state
	always_comb begin
		d = q;
		// Three-stage pin capture; a level counts once stages two and three agree
		d.s1 = {last_char_in, tape_in, code_in};
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.filt = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.filt);
		lcode = q.filt[4:0];
		// One-degree step enable from the divider
		step = (q.step_cnt == 7'h00);
		d.step_cnt = step ? 7'(tape_dist_pkg::STEP_CYCLES - 7'h01) : 7'(q.step_cnt - 7'h01);
		// Tape-out and last-character contacts break the sensing trip circuit
		sns_trip = q.ctrl[tape_dist_pkg::C_RUN] &
			(q.filt[5] | ~q.ctrl[tape_dist_pkg::C_STOP]) & // R12
			(q.filt[6] | ~q.ctrl[tape_dist_pkg::C_SER]); // R13
		sns_nx = shaft_next(q.sns_st == tape_dist_pkg::SH_RUN, q.sph, step, sns_trip); // R4
		dst_nx = shaft_next(q.dst_st == tape_dist_pkg::SH_RUN, q.dph, step, q.trip); // R1
		d.sns_st = tape_dist_pkg::shaft_t'(sns_nx[9]);
		d.sph = sns_nx[8:0]; // R15
		d.dst_st = tape_dist_pkg::shaft_t'(dst_nx[9]);
		d.dph = dst_nx[8:0]; // R15
		// Storing stage: latch the code early in each sensing turn
		if (q.sns_st == tape_dist_pkg::SH_RUN && step && q.sph == tape_dist_pkg::SENSE_LATCH) begin
			d.scode = lcode;
		end
		// Distributor takes its own copy at each start, so the next sensing turn may overlap
		if (dst_nx[9] && dst_nx[8:0] == 9'h000 && (q.dst_st == tape_dist_pkg::SH_IDLE ||
			(step && q.dph == tape_dist_pkg::PH_LAST))) begin
			d.dcode = q.scode; // R5 R14
		end
		// Trip contact from the sensing cam
		d.trip = (q.sns_st == tape_dist_pkg::SH_RUN) && (q.ctrl[tape_dist_pkg::C_ONE] ?
			in_win(q.sph, tape_dist_pkg::DTRIP1_CL, tape_dist_pkg::DTRIP1_OP) :
			in_win(q.sph, tape_dist_pkg::DTRIP2_CL, tape_dist_pkg::DTRIP2_OP)); // R2
		// Distributor outputs A and B are open and the line rests at mark while the shaft rests
		d.line = (q.dst_st == tape_dist_pkg::SH_RUN) ? line_level(q.dph, q.dcode) : 1'b1; // R6
		d.aux_a = (q.dst_st == tape_dist_pkg::SH_RUN) && (q.ctrl[tape_dist_pkg::C_ONE] ?
			in_win(q.dph, tape_dist_pkg::AUXA1_CL, tape_dist_pkg::AUXA1_OP) : // R8
			in_win(q.dph, tape_dist_pkg::AUXA2_CL, tape_dist_pkg::AUXA2_OP)); // R7
		d.aux_b = (q.dst_st == tape_dist_pkg::SH_RUN) && q.ctrl[tape_dist_pkg::C_ONE] &&
			q.ctrl[tape_dist_pkg::C_BEN] &&
			in_win(q.dph, tape_dist_pkg::AUXB_CL, tape_dist_pkg::AUXB_OP); // R9
		d.warn = q.ctrl[tape_dist_pkg::C_WARN] & ~q.filt[5]; // R10
		// Events
		ev = '0;
		ev[tape_dist_pkg::I_SENSED] = (q.sns_st == tape_dist_pkg::SH_RUN) && step &&
			(q.sph == tape_dist_pkg::PH_LAST);
		ev[tape_dist_pkg::I_SENT] = (q.dst_st == tape_dist_pkg::SH_RUN) && step &&
			(q.dph == tape_dist_pkg::PH_LAST);
		ev[tape_dist_pkg::I_TAPEOUT] = q.filt[5] & ~d.filt[5];
		ev[tape_dist_pkg::I_HALT] = (q.sns_st == tape_dist_pkg::SH_RUN) && !sns_nx[9];
		// APB: answer registered in the first access cycle, no wait states
		acc = psel & penable & q.pready;
		d.pready = psel & ~penable & ~q.pready;
		d.pslverr = psel & ~penable & ~addr_ok(paddr);
		d.prdata = '0;
		if (psel && !penable) begin
			case (paddr)
				tape_dist_pkg::CTRL_OFS: d.prdata = {26'h0, q.ctrl};
				tape_dist_pkg::STAT_OFS: d.prdata = {23'h0, q.scode, q.filt[6:5],
					q.dst_st == tape_dist_pkg::SH_RUN, q.sns_st == tape_dist_pkg::SH_RUN};
				tape_dist_pkg::PHASE_OFS: d.prdata = {7'h0, q.dph, 7'h0, q.sph};
				tape_dist_pkg::ISTAT_OFS: d.prdata = {28'h0, q.ist};
				tape_dist_pkg::IMASK_OFS: d.prdata = {28'h0, q.imask};
				default: d.prdata = '0;
			endcase
		end
		// Writes land at the access edge; a new event wins over a write-one clear
		d.ist = q.ist | ev;
		if (acc && pwrite) begin
			case (paddr)
				tape_dist_pkg::CTRL_OFS: d.ctrl = pwdata[5:0];
				tape_dist_pkg::ISTAT_OFS: d.ist = (q.ist & ~pwdata[3:0]) | ev;
				tape_dist_pkg::IMASK_OFS: d.imask = pwdata[3:0];
				default: d.ctrl = q.ctrl;
			endcase
		end
		d.irq = |(d.ist & d.imask);
	end

	// ==========================================================
	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.filt <= 7'h00;
			q.line <= 1'b1;
			q.ctrl <= tape_dist_pkg::CTRL_RST;
			q.imask <= tape_dist_pkg::IMASK_RST;
		end else begin
			q <= d;
		end
	end

	assign pready = q.pready;
	assign prdata = q.prdata;
	assign pslverr = q.pslverr;
	assign irq = q.irq;
	assign line_out = q.line;
	assign aux_a = q.aux_a;
	assign aux_b = q.aux_b;
	assign dist_trip = q.trip;
	assign tape_warn = q.warn;

	// ==========================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_dist_start;
		$rose(q.dst_st == tape_dist_pkg::SH_RUN) |-> $past(q.trip);
	endproperty
	a_dist_start: assert property (p_dist_start) else $error("distributor started untripped"); // R1

	property p_trip_win;
		(q.sns_st == tape_dist_pkg::SH_RUN && !q.ctrl[tape_dist_pkg::C_ONE] &&
			q.sph >= 9'h05E && q.sph < 9'h09C) |=> q.trip;
	endproperty
	a_trip_win: assert property (p_trip_win) else $error("trip contact not closed"); // R2

	property p_trip_off;
		(q.ctrl[tape_dist_pkg::C_ONE] && (q.sph < 9'h0F7 || q.sph >= 9'h135)) |=> !q.trip;
	endproperty
	a_trip_off: assert property (p_trip_off) else $error("trip contact closed early"); // R2

	property p_keep_turning;
		(q.dst_st == tape_dist_pkg::SH_RUN && step && q.dph == 9'h167 && q.trip)
			|=> (q.dst_st == tape_dist_pkg::SH_RUN && q.dph == 9'h000);
	endproperty
	a_keep_turning: assert property (p_keep_turning) else $error("shaft stopped while tripped"); // R3

	property p_halt_home;
		(q.dst_st == tape_dist_pkg::SH_RUN && step && q.dph == 9'h167 && !q.trip)
			|=> (q.dst_st == tape_dist_pkg::SH_IDLE && q.dph == 9'h000)[*2];
	endproperty
	a_halt_home: assert property (p_halt_home) else $error("shaft did not halt at home"); // R4

	property p_code_hold;
		(q.dst_st == tape_dist_pkg::SH_RUN && q.dph != 9'h167) |=> $stable(q.dcode);
	endproperty
	a_code_hold: assert property (p_code_hold) else $error("sent code changed mid-turn"); // R5

	property p_start_space;
		(q.dst_st == tape_dist_pkg::SH_RUN && q.dph < 9'h031) |=> !q.line;
	endproperty
	a_start_space: assert property (p_start_space) else $error("start window not spacing"); // R6

	property p_aux_a2;
		(q.dst_st == tape_dist_pkg::SH_RUN && !q.ctrl[tape_dist_pkg::C_ONE] &&
			q.dph == 9'h019) |=> q.aux_a;
	endproperty
	a_aux_a2: assert property (p_aux_a2) else $error("output A not closed at 25"); // R7

	property p_aux_a1;
		(q.ctrl[tape_dist_pkg::C_ONE] && q.dph == 9'h154) |=> !q.aux_a;
	endproperty
	a_aux_a1: assert property (p_aux_a1) else $error("output A not open at 340"); // R8

	property p_aux_b;
		q.aux_b |-> $past(q.dph) >= 9'h05F && $past(q.dph) < 9'h139 && q.ctrl[tape_dist_pkg::C_ONE];
	endproperty
	a_aux_b: assert property (p_aux_b) else $error("output B outside its window"); // R9

	property p_stop;
		(q.sns_st == tape_dist_pkg::SH_RUN && step && q.sph == 9'h167 &&
			q.ctrl[tape_dist_pkg::C_STOP] && !q.filt[5]) |=> q.sns_st == tape_dist_pkg::SH_IDLE;
	endproperty
	a_stop: assert property (p_stop) else $error("tape-out did not stop sensing"); // R12

	property p_phase_range;
		q.sph <= 9'h167 && q.dph <= 9'h167;
	endproperty
	a_phase_range: assert property (p_phase_range) else $error("phase beyond 359"); // R15

	c_overlap: cover property (q.sns_st == tape_dist_pkg::SH_RUN &&
		q.dst_st == tape_dist_pkg::SH_RUN && q.sph < 9'h05E); // R14
	c_repeat: cover property (q.dst_st == tape_dist_pkg::SH_RUN && q.dph == 9'h167 && step && q.trip);
	c_tapeout: cover property (q.warn && q.sns_st == tape_dist_pkg::SH_IDLE);
	c_irq: cover property ($rose(q.irq));
endmodule

// File: tape_line_rx.sv
module tape_line_rx (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Serial line in, decoded character out
	input wire logic line_out,
	output logic [4:0] rx_code,
	output logic rx_done
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SC = int'(tape_dist_pkg::STEP_CYCLES);
	int cnt;
	logic busy;
	// ==========================================================
	// Receiver
	// Fixed-rate receiver: start on the first space, sample each level mid-window.
	// A reset clears busy and rx_done but not rx_code, so a frame cut short is simply dropped.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy <= 1'b0;
			rx_done <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			cnt <= busy ? cnt + 1 : 0;
			if (!busy && line_out === 1'b0)
				busy <= 1'b1;
			for (int i = 0; i < 5; i++)
				if (busy && cnt == (73 + 48 * i) * SC) rx_code[i] <= line_out;
			if (busy && cnt == 300 * SC) begin
				busy <= 1'b0;
				rx_done <= 1'b1;
			end
		end
	end
endmodule

// File: test_tape_code_distributor.sv
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end

module test_tape_code_distributor;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Signals and bookkeeping
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [4:0] code_in, rx_code, c1;
	logic tape_in, last_char_in, line_out, aux_a, aux_b, dist_trip, tape_warn, rx_done;
	logic watch;
	logic [3:0] cur, prv;
	logic [31:0] eq[$];
	logic [32:0] dq[$];
	int errors, checks, cyc, t0, lim, s0g;

	// ==========================================================
	// Design and the signal circuit on its line
	tape_code_distributor uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .irq(irq), .code_in(code_in),
		.tape_in(tape_in), .last_char_in(last_char_in), .line_out(line_out),
		.aux_a(aux_a), .aux_b(aux_b), .dist_trip(dist_trip), .tape_warn(tape_warn)
	);
	tape_line_rx rx (
		.pclk(pclk), .presetn(presetn), .line_out(line_out),
		.rx_code(rx_code), .rx_done(rx_done)
	);

	// Free-running clock and cycle count
	initial pclk = 1'b0;
	always #10 pclk = ~pclk;
	always @(posedge pclk) cyc <= cyc + 1;

	// ==========================================================
	// Tasks
	task automatic finish_test();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// One APB transfer; the idle cycle in front avoids driving psel twice in one step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) errors++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic err);
		dq.push_back({err, v});
		apb(1'b0, a, 32'h0);
	endtask

	// Expected contact edge, kept sorted by angle then by contact
	task automatic ev(int d, int i, int v);
		int p;
		p = 0;
		if (d < lim) begin
			while (p < eq.size() && eq[p] < d * 8 + i * 2 + v) p++;
			eq.insert(p, d * 8 + i * 2 + v);
		end
	endtask

	// All contact and line edges of one distributor turn, in sensing degrees
	task automatic dist_evs(logic one, logic [4:0] c);
		int s0, lv;
		s0 = one ? tape_dist_pkg::DTRIP1_CL : tape_dist_pkg::DTRIP2_CL;
		s0g = s0;
		ev(s0, 0, 1);
		ev(one ? tape_dist_pkg::DTRIP1_OP : tape_dist_pkg::DTRIP2_OP, 0, 0);
		ev(s0 + (one ? tape_dist_pkg::AUXA1_CL : tape_dist_pkg::AUXA2_CL), 1, 1);
		ev(s0 + (one ? tape_dist_pkg::AUXA1_OP : tape_dist_pkg::AUXA2_OP), 1, 0);
		if (one) begin
			ev(s0 + tape_dist_pkg::AUXB_CL, 2, 1);
			ev(s0 + tape_dist_pkg::AUXB_OP, 2, 0);
		end
		ev(s0, 3, 0);
		lv = 0;
		for (int i = 0; i < 5; i++) begin
			if (c[i] != lv) ev(s0 + 49 + 48 * i, 3, c[i]);
			lv = c[i];
		end
		if (lv == 0) ev(s0 + 289, 3, 1);
	endtask

	// One sensing turn: start, then drop run at once so only one character goes out
	task automatic run(logic one, int lm, logic [31:0] ctl);
		lim = lm;
		dist_evs(one, c1);
		apb(1'b1, tape_dist_pkg::CTRL_OFS, ctl);
		// The divider runs free, so the angle origin is fixed by the trip edge
		t0 = -1;
		watch = 1'b1;
		apb(1'b1, tape_dist_pkg::CTRL_OFS, ctl & 32'hFFFFFFFE);
	endtask

	// ==========================================================
	// Monitors: read data and received characters, then contact edges
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite)
			`CHK({pslverr, prdata}, dq.size() > 0 ? dq.pop_front() : '1)
		if (rx_done === 1'b1)
			`CHK({28'h0, rx_code}, dq.size() > 0 ? dq.pop_front() : '1)
	end
	always @(posedge pclk) begin
		cur = {line_out, aux_b, aux_a, dist_trip};
		if (watch && t0 < 0 && dist_trip === 1'b1)
			t0 = cyc - s0g * int'(tape_dist_pkg::STEP_CYCLES);
		if (watch)
			for (int i = 0; i < 4; i++)
				if (cur[i] !== prv[i])
					`CHK(32'((cyc - t0 + 50) / 100 * 8 + i * 2 + cur[i]), eq.size() > 0 ? eq.pop_front() : '1)
		prv = cur;
	end

	// Watchdog, well past the planned run of about 81400 cycles
	initial begin
		#(98000 * 20);
		errors++;
		finish_test();
	end

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'h4053));
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{presetn, watch, code_in} = '0;
		{tape_in, last_char_in} = 2'b11;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(tape_dist_pkg::CTRL_OFS, 32'h0, 1'b0);
		rd(tape_dist_pkg::IMASK_OFS, 32'h0, 1'b0);
		rd(8'h14, 32'h0, 1'b1);
		$display("test registers done");
		// Tape runs out: sticky event, masked, unmasked, cleared
		tape_in <= 1'b0;
		repeat (5) @(posedge pclk);
		rd(tape_dist_pkg::ISTAT_OFS, 32'h4, 1'b0);
		`CHK(irq, 1'b0)
		apb(1'b1, tape_dist_pkg::IMASK_OFS, 32'h4);
		repeat (3) @(posedge pclk);
		`CHK(irq, 1'b1)
		apb(1'b1, tape_dist_pkg::ISTAT_OFS, 32'h4);
		repeat (3) @(posedge pclk);
		`CHK(irq, 1'b0)
		// Installation picks warning and stop together
		apb(1'b1, tape_dist_pkg::CTRL_OFS, 32'h19);
		repeat (5) @(posedge pclk);
		`CHK(tape_warn, 1'b1)
		rd(tape_dist_pkg::STAT_OFS, 32'h8, 1'b0);
		apb(1'b1, tape_dist_pkg::CTRL_OFS, 32'h0);
		last_char_in <= 1'b0;
		tape_in <= 1'b1;
		repeat (5) @(posedge pclk);
		apb(1'b1, tape_dist_pkg::CTRL_OFS, 32'h21);
		repeat (5) @(posedge pclk);
		rd(tape_dist_pkg::STAT_OFS, 32'h4, 1'b0);
		apb(1'b1, tape_dist_pkg::CTRL_OFS, 32'h0);
		last_char_in <= 1'b1;
		apb(1'b1, tape_dist_pkg::ISTAT_OFS, 32'hF);
		$display("test stops done");
		// Two-cycle gearing; the tape code changes after the latch point
		c1 = 5'($urandom);
		code_in <= c1;
		repeat (5) @(posedge pclk);
		dq.push_back({28'h0, c1});
		run(1'b0, 1000, 32'h5);
		repeat (4000) @(posedge pclk);
		code_in <= ~c1;
		repeat (43000) @(posedge pclk);
		watch = 1'b0;
		`CHK(eq.size(), 0)
		rd(tape_dist_pkg::ISTAT_OFS, 32'hB, 1'b0);
		rd(tape_dist_pkg::STAT_OFS, {23'h0, c1, 4'hC}, 1'b0);
		$display("test two_cycle done");
		// One-cycle gearing with output B, cut short by a reset mid-turn
		c1 = ~c1;
		apb(1'b1, tape_dist_pkg::ISTAT_OFS, 32'hF);
		run(1'b1, 343, 32'h7);
		repeat (34250) @(posedge pclk);
		watch = 1'b0;
		`CHK(eq.size(), 0)
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(tape_dist_pkg::PHASE_OFS, 32'h0, 1'b0);
		repeat (3) @(posedge pclk);
		`CHK(dq.size(), 0)
		$display("test one_cycle done");
		finish_test();
	end
endmodule
